// ==== core/gpio_pkg.sv ====
// gpio_pkg: register map, reset values and field layout of the gpio port block
// assumes an apb slave with 32-bit data; each register but the 32-bit status sits in the low byte of a word
package gpio_pkg;

	localparam int NUM_PORTS = 4;
	localparam int PORT_W = 8;
	localparam int NUM_PINS = 31;
	localparam int ADDR_W = 8;

	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_PORT0_DATA = 6'h00;
	localparam logic [5:0] IDX_PORT1_DATA = 6'h01;
	localparam logic [5:0] IDX_PORT2_DATA = 6'h02;
	localparam logic [5:0] IDX_PORT3_DATA = 6'h03;
	localparam logic [5:0] IDX_PORT0_IRQ_EN = 6'h04;
	localparam logic [5:0] IDX_PORT1_IRQ_EN = 6'h05;
	localparam logic [5:0] IDX_PORT2_IRQ_EN = 6'h06;
	localparam logic [5:0] IDX_PORT3_IRQ_EN = 6'h07;
	localparam logic [5:0] IDX_DRIVE_MODE_CFG = 6'h08;
	localparam logic [5:0] IDX_IRQ_CTRL = 6'h09;
	localparam logic [5:0] IDX_IRQ_STATUS = 6'h0a;

	// reset values
	localparam logic [31:0] DATA_RST = 32'hffffffff;
	localparam logic [31:0] IRQ_EN_RST = 32'h00000000;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [31:0] STATUS_RST = 32'h00000000;

	// irq_ctrl fields
	localparam int CTRL_GLOBAL_EN_BIT = 0;
	localparam int CTRL_SENSE_BIT = 2;
	localparam int CTRL_PAR_LSB = 4;

	// per-port drive modes (config bit 1, bit 0)
	localparam logic [1:0] MODE_HIZ_RISE = 2'h0;
	localparam logic [1:0] MODE_HIZ_FALL = 2'h1;
	localparam logic [1:0] MODE_PUSH_PULL = 2'h2;
	localparam logic [1:0] MODE_RESISTIVE = 2'h3;

	// pin drive bundle, one bit per pin
	typedef struct packed {
		logic [NUM_PINS-1:0] level;
		logic [NUM_PINS-1:0] oe;
		logic [NUM_PINS-1:0] res_pullup;
	} pin_drive_s;

	// two-stage synchroniser bundle
	typedef struct packed {
		logic [NUM_PINS-1:0] meta;
		logic [NUM_PINS-1:0] sync;
		logic [NUM_PINS-1:0] prev;
	} pin_sample_s;

endpackage

// ==== core/gpio_ports.sv ====
// gpio_ports: four gpio ports with per-port drive modes and edge interrupts
// assumes apb3 master on CLK_SYS; pin pads resolve level from level/oe/pullup
//
// Operation
// - 31 pins: ports 0-2 full, port 3 bits 6:0
// - data registers reset to all ones
// - port read returns synchronised pin level
// - parallel mode port reads return latched data
// - reset leaves every pin high impedance
// - data zero drives pin low always
// - mode 10 with one drives high, no interrupt
// - mode 11 with one: resistive pull-up, falling
// - modes 00/01 with one: all drivers off
// - mode 00 rising edge, 01/11 falling edge
// - interrupt needs pin, global, sense enables
// - push-pull port never raises interrupts
// - port n mode in config bits 2n+1:2n
// - config register resets to zero, Hi-Z
// - parallel mode blocks every pin interrupt
// - write-only per-pin enables, reset cleared
//
// Added by the designer: the APB slave port.
`timescale 1ns/100ps
`default_nettype none

module gpio_ports (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_N,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [gpio_pkg::ADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// pins
	input wire logic [gpio_pkg::NUM_PINS-1:0] GPIO_IN,
	output logic [gpio_pkg::NUM_PINS-1:0] GPIO_OUT,
	output logic [gpio_pkg::NUM_PINS-1:0] GPIO_OE,
	output logic [gpio_pkg::NUM_PINS-1:0] GPIO_RES_PULLUP,
	// parallel assist latch strobe from the handshake logic
	input wire logic PAR_LATCH_STB,
	// interrupt
	output logic IRQ
);

	// mode of the port that holds a pin
	function automatic logic [1:0] pin_mode(input logic [7:0] cfg, input int pin);
		int port;
		port = pin / gpio_pkg::PORT_W;
		pin_mode = cfg[2*port +: 2];
	endfunction

	// extend the 31 pin bits to a 32 bit port image
	function automatic logic [31:0] to_ports(input logic [gpio_pkg::NUM_PINS-1:0] v);
		to_ports = {1'b0, v};
	endfunction

	// widen a per-port flag to every pin of that port
	function automatic logic [gpio_pkg::NUM_PINS-1:0] spread(input logic [3:0] p);
		logic [gpio_pkg::NUM_PINS-1:0] v;
		v = '0;
		for (int i = 0; i < gpio_pkg::NUM_PINS; i++) begin
			v[i] = p[i / gpio_pkg::PORT_W];
		end
		spread = v;
	endfunction

	// ports whose two mode bits equal a code
	function automatic logic [3:0] ports_in_mode(input logic [7:0] cfg, input logic [1:0] code);
		logic [3:0] v;
		v = '0;
		for (int i = 0; i < gpio_pkg::NUM_PORTS; i++) begin
			v[i] = (cfg[2*i +: 2] == code);
		end
		ports_in_mode = v;
	endfunction

	// registers
	logic [31:0] data_ff;
	logic [31:0] irq_en_ff;
	logic [7:0] cfg_ff;
	logic [7:0] ctrl_ff;
	logic [31:0] status_ff;
	logic [31:0] prdata_ff;
	logic [31:0] rd_clear_ff;
	logic pready_ff;
	gpio_pkg::pin_sample_s pins_ff;
	gpio_pkg::pin_drive_s drive_ff;
	logic [gpio_pkg::NUM_PINS-1:0] par_latch_ff;
	logic [2:0] stb_ff;
	logic irq_ff;

	// next values
	logic [31:0] nxt_data;
	logic [31:0] nxt_irq_en;
	logic [7:0] nxt_cfg;
	logic [7:0] nxt_ctrl;
	logic [31:0] nxt_status;
	gpio_pkg::pin_drive_s nxt_drive;

	// register map, byte address = 4 * index, value in the low byte except the 32-bit status:
	//   0-3  port data; writes set the drive, reads return the pins
	//   4-7  per-pin interrupt enables, write-only, read as zero
	//   8    drive mode, two bits per port
	//   9    global enable, sense enable, parallel port select
	//   10   sticky edge status, cleared by reading it
	// unmapped or misaligned addresses answer with an error

	// apb decode
	wire setup_ph = PSEL & ~PENABLE;
	wire access_ph = PSEL & PENABLE;
	wire [5:0] idx = PADDR[7:2];
	wire aligned = (PADDR[1:0] == 2'h0);
	wire hit_data = aligned & (idx <= gpio_pkg::IDX_PORT3_DATA);
	wire hit_irq_en = aligned & (idx >= gpio_pkg::IDX_PORT0_IRQ_EN)
		& (idx <= gpio_pkg::IDX_PORT3_IRQ_EN);
	wire hit_cfg = aligned & (idx == gpio_pkg::IDX_DRIVE_MODE_CFG);
	wire hit_ctrl = aligned & (idx == gpio_pkg::IDX_IRQ_CTRL);
	wire hit_status = aligned & (idx == gpio_pkg::IDX_IRQ_STATUS);
	wire mapped = hit_data | hit_irq_en | hit_cfg | hit_ctrl | hit_status;
	wire wr_done = access_ph & PWRITE & pready_ff & mapped;
	wire rd_done = access_ph & ~PWRITE & pready_ff & mapped;
	wire [1:0] lane = idx[1:0];

	// control fields
	wire global_en = ctrl_ff[gpio_pkg::CTRL_GLOBAL_EN_BIT];
	wire sense_en = ctrl_ff[gpio_pkg::CTRL_SENSE_BIT];
	wire [3:0] par_port_en = ctrl_ff[gpio_pkg::CTRL_PAR_LSB +: 4];
	wire par_active = |par_port_en;

	// pin events
	wire [gpio_pkg::NUM_PINS-1:0] rise = pins_ff.sync & ~pins_ff.prev;
	wire [gpio_pkg::NUM_PINS-1:0] fall = ~pins_ff.sync & pins_ff.prev;
	logic [gpio_pkg::NUM_PINS-1:0] pin_event;
	logic [gpio_pkg::NUM_PINS-1:0] par_pin;

	genvar gi;
	generate
		for (gi = 0; gi < gpio_pkg::NUM_PINS; gi++) begin : g_pin
			wire [1:0] m = pin_mode(cfg_ff, gi);
			wire d = data_ff[gi];
			// low drive wins whatever the mode
			assign nxt_drive.oe[gi] = ~d | (m == gpio_pkg::MODE_PUSH_PULL);
			assign nxt_drive.level[gi] = d & (m == gpio_pkg::MODE_PUSH_PULL);
			assign nxt_drive.res_pullup[gi] = d & (m == gpio_pkg::MODE_RESISTIVE);
			assign par_pin[gi] = par_port_en[gi / gpio_pkg::PORT_W];
			// polarity per port; push-pull ports have none
			assign pin_event[gi] = ~par_active & (
				((m == gpio_pkg::MODE_HIZ_RISE) & rise[gi])
				| ((m == gpio_pkg::MODE_HIZ_FALL) & fall[gi])
				| ((m == gpio_pkg::MODE_RESISTIVE) & fall[gi]));
		end
	endgenerate

	// read image of the ports
	wire [31:0] live_ports = to_ports(pins_ff.sync);
	wire [31:0] latched_ports = to_ports(par_latch_ff);
	wire [31:0] par_sel = to_ports(par_pin);
	wire [31:0] port_image = (live_ports & ~par_sel) | (latched_ports & par_sel);
	wire [7:0] port_byte = port_image[8*lane +: 8];

	wire [31:0] rd_word =
		hit_data ? {24'h000000, port_byte} :
		hit_cfg ? {24'h000000, cfg_ff} :
		hit_ctrl ? {24'h000000, ctrl_ff} :
		hit_status ? status_ff :
		32'h00000000; // enables are write-only and read zero

	// write decode
	always_comb begin
		nxt_data = data_ff;
		nxt_irq_en = irq_en_ff;
		nxt_cfg = cfg_ff;
		nxt_ctrl = ctrl_ff;
		if (wr_done & hit_data) begin
			nxt_data[8*lane +: 8] = PWDATA[7:0];
		end
		if (wr_done & hit_irq_en) begin
			nxt_irq_en[8*lane +: 8] = PWDATA[7:0];
		end
		if (wr_done & hit_cfg) begin
			nxt_cfg = PWDATA[7:0];
		end
		if (wr_done & hit_ctrl) begin
			nxt_ctrl = PWDATA[7:0];
		end
	end

	// new events set, read-clear only drops what the read captured
	always_comb begin
		nxt_status = status_ff;
		if (rd_done & hit_status) begin
			nxt_status = status_ff & ~rd_clear_ff;
		end
		nxt_status = nxt_status | to_ports(pin_event);
	end

	// push-pull ports stay silent even with bits latched before the mode change
	wire [3:0] pp_ports = ports_in_mode(cfg_ff, gpio_pkg::MODE_PUSH_PULL);
	wire [gpio_pkg::NUM_PINS-1:0] pp_pins = spread(pp_ports);
	wire [31:0] irq_gate = ~to_ports(pp_pins);
	wire [31:0] pending = status_ff & irq_en_ff & irq_gate;
	// parallel mode blocks the shared request, not just new events
	wire irq_blocked = par_active;

	// pin enable, global enable and sense enable all required
	wire irq_req = (|pending) & global_en & sense_en & ~irq_blocked;

	// registers; one short process per register
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			data_ff <= gpio_pkg::DATA_RST;
		end else begin
			data_ff <= nxt_data;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			irq_en_ff <= gpio_pkg::IRQ_EN_RST;
		end else begin
			irq_en_ff <= nxt_irq_en;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			cfg_ff <= gpio_pkg::CFG_RST;
		end else begin
			cfg_ff <= nxt_cfg;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			ctrl_ff <= gpio_pkg::CTRL_RST;
		end else begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	// sticky edge status; a new event outranks the read clear
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			status_ff <= gpio_pkg::STATUS_RST;
		end else begin
			status_ff <= nxt_status;
		end
	end

	// registered request keeps the interrupt line free of decode glitches
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= irq_req;
		end
	end

	// apb answer: data captured in setup, ready in access
	// zero wait states: ready follows every setup cycle by one edge
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			pready_ff <= 1'b0;
		end else begin
			pready_ff <= setup_ph;
		end
	end

	// read data frozen in setup so a pin change in access cannot tear it
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			prdata_ff <= 32'h00000000;
		end else if (setup_ph & ~PWRITE) begin
			prdata_ff <= rd_word;
		end
	end

	// only the bits handed out by this read may be cleared by it
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			rd_clear_ff <= 32'h00000000;
		end else if (setup_ph & ~PWRITE) begin
			rd_clear_ff <= hit_status ? status_ff : 32'h00000000;
		end
	end

	// pin synchroniser; meta feeds only sync
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			// idle pins sit high; a zero here would fake a rise after reset
			pins_ff <= '1;
		end else begin
			pins_ff.meta <= GPIO_IN;
			pins_ff.sync <= pins_ff.meta;
			pins_ff.prev <= pins_ff.sync;
		end
	end

	// strobe synchroniser; its edge is taken past the second stage
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			stb_ff <= 3'h0;
		end else begin
			stb_ff <= {stb_ff[1:0], PAR_LATCH_STB};
		end
	end

	// parallel assist latch on the strobe's rising edge
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			par_latch_ff <= '0;
		end else if (stb_ff[1] & ~stb_ff[2]) begin
			par_latch_ff <= pins_ff.sync;
		end
	end

	// pin drive registered; reset state is all drivers off
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			drive_ff <= '0;
		end else begin
			drive_ff <= nxt_drive;
		end
	end

	assign GPIO_OUT = drive_ff.level;
	assign GPIO_OE = drive_ff.oe;
	assign GPIO_RES_PULLUP = drive_ff.res_pullup;
	assign PRDATA = prdata_ff;
	assign PREADY = pready_ff;
	assign PSLVERR = access_ph & pready_ff & ~mapped;
	assign IRQ = irq_ff;

endmodule

`default_nettype wire

// ==== tb/gpio_board.sv ====
// gpio_board: pads and outside drivers on the gpio pins
// assumes the bench sets ext_en/ext_val
`timescale 1ns/100ps
`default_nettype none
module gpio_board (
	// clock
	input wire logic clk,
	// from block and bench
	input wire logic [30:0] out,
	input wire logic [30:0] oe,
	input wire logic [30:0] pu,
	input wire logic [30:0] ext_en,
	input wire logic [30:0] ext_val,
	// resolved level
	output logic [30:0] pin
);
	logic [30:0] last_ff;
	// no keeper: a floating pin wanders every cycle
	always_ff @(posedge clk) last_ff <= pin;
	assign pin = (oe & out) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & (pu | ~last_ff));
endmodule
`default_nettype wire

// ==== tb/gpio_ports_props.sv ====
// gpio_ports_props: port-level checks for the gpio block
// assumes bind onto gpio_ports
`timescale 1ns/100ps
`default_nettype none
module gpio_ports_props (
	// clock, reset, apb
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [gpio_pkg::ADDR_W-1:0] PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	// pins, interrupt
	input wire logic [gpio_pkg::NUM_PINS-1:0] GPIO_OUT,
	input wire logic [gpio_pkg::NUM_PINS-1:0] GPIO_OE,
	input wire logic [gpio_pkg::NUM_PINS-1:0] GPIO_RES_PULLUP,
	input wire logic IRQ
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	wire rd_acc = PSEL && PENABLE && !PWRITE;
	property p_rst_hiz;
		disable iff (1'b0) !RST_N |-> (GPIO_OE | GPIO_RES_PULLUP) == '0;
	endproperty
	a_rst_hiz: assert property (p_rst_hiz) else $error("pin driven in reset");
	property p_pu_alone;
		(GPIO_OE & GPIO_RES_PULLUP) == '0;
	endproperty
	a_pu_alone: assert property (p_pu_alone) else $error("pullup with driver");
	property p_ready_next;
		PSEL && !PENABLE |=> PREADY;
	endproperty
	a_ready_next: assert property (p_ready_next) else $error("no ready");
	property p_ready_acc;
		PREADY |-> PSEL && PENABLE;
	endproperty
	a_ready_acc: assert property (p_ready_acc) else $error("stray ready");
	property p_err;
		PREADY && (PADDR[1:0] != 2'h0 || PADDR[7:2] > 6'h0a) |-> PSLVERR;
	endproperty
	a_err: assert property (p_err) else $error("no slverr");
	// drive changes only two edges after an accepted write
	property p_pins_hold;
		!(PSEL && PENABLE && PWRITE) |-> ##2 $stable({GPIO_OE, GPIO_OUT, GPIO_RES_PULLUP});
	endproperty
	a_pins_hold: assert property (p_pins_hold) else $error("drive moved");
	property p_port3_top;
		rd_acc && PADDR == 8'h0c |-> PRDATA[31:7] == '0;
	endproperty
	a_port3_top: assert property (p_port3_top) else $error("port3 top set");
	property p_en_wo;
		rd_acc && PADDR[7:4] == 4'h1 |-> PRDATA == 32'h0;
	endproperty
	a_en_wo: assert property (p_en_wo) else $error("enable readable");
	c_irq: cover property ($rose(IRQ));
	c_err: cover property (PREADY && PSLVERR);
	c_pu: cover property (GPIO_RES_PULLUP != '0);
endmodule
bind gpio_ports gpio_ports_props gpio_ports_props_inst (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .GPIO_OUT(GPIO_OUT), .GPIO_OE(GPIO_OE),
	.GPIO_RES_PULLUP(GPIO_RES_PULLUP), .IRQ(IRQ));
`default_nettype wire

// ==== tb/gpio_ports_bench.sv ====
// gpio_ports_bench: self-checking bench for the gpio block
// assumes gpio_board on the pins; apb master here
`timescale 1ns/100ps
`default_nettype none
module gpio_ports_bench;
	logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, err, par_stb = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, irq;
	logic [30:0] g_out, g_oe, g_pu, pins, ext_en = '1, ext_val = '1;
	int n_fail = 0, tests_run = 0;
	initial forever #5 clk = ~clk;
	gpio_ports gpio_ports_inst (.CLK_SYS(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen),
		.PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .GPIO_IN(pins), .GPIO_OUT(g_out), .GPIO_OE(g_oe),
		.GPIO_RES_PULLUP(g_pu), .PAR_LATCH_STB(par_stb), .IRQ(irq));
	gpio_board gpio_board_inst (.clk(clk), .out(g_out), .oe(g_oe), .pu(g_pu),
		.ext_en(ext_en), .ext_val(ext_val), .pin(pins));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge clk);
		end
		if (pready !== 1'b1) begin
			n_fail++;
			$display("unexpected pready: expected 1, seen %b", pready);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		// one idle edge so the next call never retimes psel in this step
		@(posedge clk);
	endtask
	task automatic t_reset();
		chk("oe", 32'h0, g_oe);
		chk("pullup", 32'h0, g_pu);
		apb(0, 8'h20, 0);
		chk("cfg", 32'h0, rd);
		apb(0, 8'h10, 0);
		chk("enable", 32'h0, rd);
		ext_val <= 31'h1234_5678;
		repeat (3) @(posedge clk);
		apb(0, 8'h00, 0);
		chk("port0", 32'h78, rd);
		apb(0, 8'h0c, 0);
		chk("port3", 32'h12, rd);
		apb(0, 8'h2c, 0);
		chk("slverr", 32'h1, err);
		chk("slverr rdata", 32'h0, rd);
		apb(1, 8'h0c, 32'h7f);
		apb(0, 8'h0c, 0);
		chk("port3 top", 32'h12, rd);
		ext_val <= '1;
	endtask
	task automatic t_drive();
		apb(1, 8'h20, 32'h2);
		repeat (2) @(posedge clk);
		chk("push oe", 32'hff, g_oe[7:0]);
		chk("push out", 32'hff, g_out[7:0]);
		apb(1, 8'h00, 32'h0f);
		apb(1, 8'h20, 32'h3);
		ext_en <= 31'h7fff_ff00;
		repeat (3) @(posedge clk);
		chk("res oe", 32'hf0, g_oe[7:0]);
		chk("res pu", 32'h0f, g_pu[7:0]);
		apb(0, 8'h00, 0);
		chk("pin read", 32'h0f, rd);
		apb(1, 8'h20, 32'h1);
		repeat (2) @(posedge clk);
		chk("hiz oe", 32'hf0, g_oe[7:0]);
		chk("hiz pu", 32'h0, g_pu[7:0]);
		apb(1, 8'h00, 32'hff);
		ext_en <= '1;
	endtask
	// port 0 latched by the parallel strobe, port 1 stays live
	task automatic t_par();
		ext_val[7:0] <= 8'h5a;
		repeat (3) @(posedge clk);
		par_stb <= 1'b1;
		repeat (5) @(posedge clk);
		par_stb <= 1'b0;
		apb(1, 8'h24, 32'h10);
		ext_val[7:0] <= 8'ha5;
		repeat (3) @(posedge clk);
		apb(0, 8'h00, 0);
		chk("latched port0", 32'h5a, rd);
		apb(0, 8'h04, 0);
		chk("live port1", 32'hff, rd);
		apb(1, 8'h24, 32'h0);
		ext_val <= '1;
	endtask
	// pin 8 (port 1 bit 0) rises then falls
	task automatic t_irq(input logic [1:0] m, input logic [7:0] c, input logic er, ef);
		logic [31:0] st_rise, st_fall;
		st_rise = (m == 2'h0 && c[7:4] == 4'h0) ? 32'h00000100 : 32'h00000000;
		st_fall = (m[0] && c[7:4] == 4'h0) ? 32'h00000100 : 32'h00000000;
		apb(1, 8'h20, {28'h0, m, 2'h0});
		apb(1, 8'h14, 32'h1);
		apb(1, 8'h24, {24'h0, c});
		ext_val[8] <= 1'b0;
		repeat (6) @(posedge clk);
		apb(0, 8'h28, 0);
		ext_val[8] <= 1'b1;
		repeat (5) @(posedge clk);
		chk("irq rise", er, irq);
		apb(0, 8'h28, 0);
		chk("status rise", st_rise, rd);
		repeat (2) @(posedge clk);
		chk("irq clear", 32'h0, irq);
		ext_val[8] <= 1'b0;
		repeat (5) @(posedge clk);
		chk("irq fall", ef, irq);
		apb(0, 8'h28, 0);
		chk("status fall", st_fall, rd);
	endtask
	task automatic end_of_test();
		$display("comparisons %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_drive();
		t_par();
		t_irq(2'h0, 8'h05, 1, 0);
		t_irq(2'h1, 8'h05, 0, 1);
		t_irq(2'h2, 8'h05, 0, 0);
		t_irq(2'h3, 8'h05, 0, 1);
		t_irq(2'h0, 8'h04, 0, 0);
		t_irq(2'h0, 8'h01, 0, 0);
		t_irq(2'h0, 8'h25, 0, 0);
		end_of_test();
	end
	initial begin
		#20000;
		n_fail++;
		end_of_test();
	end
endmodule
`default_nettype wire
